/* File: hdl/sbr_device.sv */
// Device end: serial slave giving burst access to 16-bit registers
// Function
// - Serial clock idles low between transfers.
// - Launch on rising edge, capture on falling.
// - Master drives first bit at first rise.
// - Only the master clocks and starts transfers.
// - First word after select is the command.
// - Every word is sixteen serial clocks.
// - Partial word dropped; no write, no more bits.
// - Deselect ends operation; new command needed.
// - Data words follow command with no gap.
// - Command: direction, page, start, end address.
// - Direction one reads, zero writes.
// - Page codes 0 and 1 valid, others reserved.
// - End not above start: start address only.
// - Burst walks addresses upward, start to end.
// - Read past end address shifts out zeros.
// - Write past end address is discarded.
// - Output released while deselected.
// - Reserved locations read zero, ignore writes.
`default_nettype none
module sbr_device
	import sbr_pkg::*;
(
	input  wire logic              clock,
	input  wire logic              reset_n,
	sbr_if.device                  link,
	output logic                   reg_page,
	output logic [ADDR_W-1:0]      reg_addr,
	output logic [WORD_W-1:0]      reg_wdata,
	output logic                   reg_wr_stb,
	output logic                   reg_rd_stb,
	input  wire logic [WORD_W-1:0] reg_rdata
);
	logic                 sclk_s;
	logic                 sel_s;
	logic                 mosi_s;
	logic                 sclk_d_reg;
	logic                 sel_d_reg;
	logic                 sclk_rise;
	logic                 sclk_fall;
	logic                 selected;
	logic                 select_start;
	logic [BIT_CNT_W-1:0] bit_reg;
	logic [WORD_W-1:0]    rx_reg;
	logic [WORD_W-1:0]    rx_word;
	logic                 word_done;
	sbr_dev_state_t       state_reg;
	logic                 dir_read_reg;
	logic                 page_ok_reg;
	logic                 page_reg;
	logic                 single_reg;
	logic                 past_end_reg;
	logic [ADDR_W-1:0]    cur_addr_reg;
	logic [ADDR_W-1:0]    end_addr_reg;
	logic                 at_end;
	logic                 cmd_done;
	logic                 data_done;
	logic [ADDR_W-1:0]    cmd_start;
	logic [ADDR_W-1:0]    cmd_end;
	logic                 cmd_page_ok;
	logic                 load_pend_reg;
	logic                 load_zero_reg;
	logic [WORD_W-1:0]    tx_reg;

	// Link pins enter the clock domain through two flip-flops
	// Select enters inverted so the synchroniser's reset value means deselected
	sbr_sync #(
		.WIDTH(3)
	) u_sync (
		.clock   (clock),
		.reset_n (reset_n),
		.async_in({link.sclk, ~link.ss_n, link.mosi}),
		.sync_out({sclk_s, sel_s, mosi_s})
	);

	// Delayed copies for edge detection
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			sclk_d_reg <= 1'h0;
			sel_d_reg  <= 1'h0;
		end else begin
			sclk_d_reg <= sclk_s;
			sel_d_reg  <= sel_s;
		end
	end

	// Edge and framing terms
	assign sclk_rise    = sclk_s & ~sclk_d_reg;
	assign sclk_fall    = ~sclk_s & sclk_d_reg;
	assign selected     = sel_s;
	assign select_start = sel_s & ~sel_d_reg;
	assign rx_word      = {rx_reg[WORD_W-2:0], mosi_s};
	assign word_done    = selected & sclk_fall & (bit_reg == LAST_BIT);

	// Command fields
	assign cmd_start   = rx_word[CMD_SADR_HI:CMD_SADR_LO];
	assign cmd_end     = rx_word[CMD_EADR_HI:CMD_EADR_LO];
	assign cmd_page_ok = ~rx_word[CMD_PGH_BIT];
	assign cmd_done    = word_done & (state_reg == DEV_CMD);
	assign data_done   = word_done & (state_reg == DEV_DATA) & ~past_end_reg;
	assign at_end      = single_reg | (cur_addr_reg == end_addr_reg);

	// Receive shifter; its bit count is cleared whenever the device is deselected
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			bit_reg <= '0;
			rx_reg  <= WORD_ZERO;
		end else if (!selected) begin
			bit_reg <= '0;
		end else if (sclk_fall) begin
			rx_reg  <= rx_word;
			bit_reg <= bit_reg + 4'h1;
		end
	end

	// Transaction control and address walk
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state_reg    <= DEV_IDLE;
			dir_read_reg <= 1'h0;
			page_ok_reg  <= 1'h0;
			page_reg     <= 1'h0;
			single_reg   <= 1'h0;
			past_end_reg <= 1'h0;
			cur_addr_reg <= '0;
			end_addr_reg <= '0;
		end else if (!selected) begin
			state_reg    <= DEV_IDLE;
			past_end_reg <= 1'h0;
		end else begin
			unique case (state_reg)
				DEV_IDLE: begin
					if (select_start) begin
						state_reg <= DEV_CMD;
					end
				end
				DEV_CMD: begin
					if (cmd_done) begin
						state_reg    <= DEV_DATA;
						dir_read_reg <= (rx_word[CMD_DIR_BIT] == DIR_READ);
						page_ok_reg  <= cmd_page_ok;
						page_reg     <= rx_word[CMD_PGL_BIT];
						cur_addr_reg <= cmd_start;
						end_addr_reg <= cmd_end;
						single_reg   <= (cmd_end <= cmd_start);
						past_end_reg <= 1'h0;
					end
				end
				DEV_DATA: begin
					if (data_done) begin
						if (at_end) begin
							past_end_reg <= 1'h1;
						end else begin
							cur_addr_reg <= cur_addr_reg + ADDR_ONE;
						end
					end
				end
			endcase
		end
	end

	// Register side strobes: one read ahead, writes on a full word only
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			reg_page      <= 1'h0;
			reg_addr      <= '0;
			reg_wdata     <= WORD_ZERO;
			reg_wr_stb    <= 1'h0;
			reg_rd_stb    <= 1'h0;
			load_pend_reg <= 1'h0;
			load_zero_reg <= 1'h0;
		end else begin
			reg_wr_stb    <= 1'h0;
			reg_rd_stb    <= 1'h0;
			load_pend_reg <= 1'h0;
			if (cmd_done && rx_word[CMD_DIR_BIT] == DIR_READ) begin
				reg_page      <= rx_word[CMD_PGL_BIT];
				reg_addr      <= cmd_start;
				reg_rd_stb    <= cmd_page_ok;
				load_pend_reg <= 1'h1;
				load_zero_reg <= ~cmd_page_ok;
			end else if (data_done && dir_read_reg && !at_end) begin
				reg_addr      <= cur_addr_reg + ADDR_ONE;
				reg_rd_stb    <= page_ok_reg;
				load_pend_reg <= 1'h1;
				load_zero_reg <= ~page_ok_reg;
			end else if (data_done && !dir_read_reg) begin
				reg_page   <= page_reg;
				reg_addr   <= cur_addr_reg;
				reg_wdata  <= rx_word;
				reg_wr_stb <= page_ok_reg;
			end
		end
	end

	// Transmit shifter: zero fill means words past the end read zero
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			tx_reg        <= WORD_ZERO;
			link.miso_out <= 1'h0;
			link.miso_oe  <= 1'h0;
		end else if (!selected) begin
			tx_reg        <= WORD_ZERO;
			link.miso_out <= 1'h0;
			link.miso_oe  <= 1'h0;
		end else begin
			link.miso_oe <= 1'h1;
			if (load_pend_reg) begin
				tx_reg <= load_zero_reg ? WORD_ZERO : reg_rdata;
			end else if (sclk_rise) begin
				link.miso_out <= tx_reg[WORD_W-1];
				tx_reg        <= {tx_reg[WORD_W-2:0], 1'h0};
			end
		end
	end
endmodule
`default_nettype wire

/* File: hdl/sbr_pkg.sv */
// Shared constants and types for the serial burst register access link
`default_nettype none
package sbr_pkg;
	// Word and field widths
	localparam int WORD_W     = 16;
	localparam int ADDR_W     = 5;
	localparam int PAGE_W     = 2;
	localparam int BIT_CNT_W  = 4;
	// Command word field positions
	localparam int CMD_DIR_BIT = 15;
	localparam int CMD_PGH_BIT = 13;
	localparam int CMD_PGL_BIT = 12;
	localparam int CMD_SADR_HI = 10;
	localparam int CMD_SADR_LO = 6;
	localparam int CMD_EADR_HI = 4;
	localparam int CMD_EADR_LO = 0;
	// Field values
	localparam logic                 DIR_READ   = 1'h1;
	localparam logic [BIT_CNT_W-1:0] LAST_BIT   = 4'hF;
	localparam logic [WORD_W-1:0]    WORD_ZERO  = 16'h0000;
	localparam logic [ADDR_W-1:0]    ADDR_ONE   = 5'h01;
	// Timing of the serial clock made by the host
	localparam int CLK_PERIOD_NS = 10;
	localparam int SCLK_HALF_NS  = 80;
	localparam int SCLK_HALF_CYC = SCLK_HALF_NS / CLK_PERIOD_NS;
	localparam int MIN_HALF_CYC  = 6;
	// Device end states
	typedef enum logic [2:0] {
		DEV_IDLE = 3'h1,
		DEV_CMD  = 3'h2,
		DEV_DATA = 3'h4
	} sbr_dev_state_t;
	// Host end states
	typedef enum logic [3:0] {
		HST_IDLE = 4'h1,
		HST_LEAD = 4'h2,
		HST_RUN  = 4'h4,
		HST_LAG  = 4'h8
	} sbr_host_state_t;
endpackage
`default_nettype wire

/* File: hdl/sbr_if.sv */
// Serial link between host end and device end
`default_nettype none
interface sbr_if;
	logic sclk;
	logic ss_n;
	logic mosi;
	logic miso_out;
	logic miso_oe;
	modport device (
		input  sclk,
		input  ss_n,
		input  mosi,
		output miso_out,
		output miso_oe
	);
	modport host (
		output sclk,
		output ss_n,
		output mosi,
		input  miso_out,
		input  miso_oe
	);
endinterface
`default_nettype wire

/* File: hdl/sbr_sync.sv */
// Two-stage synchroniser for signals from outside the clock domain
`default_nettype none
module sbr_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clock,
	input  wire logic             reset_n,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_reg;

	initial begin
		if (WIDTH < 1) $error("sbr_sync: WIDTH must be at least 1");
	end

	// Both stages, second stage is the only reader of the first
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			meta_reg <= '0;
			sync_out <= '0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule
`default_nettype wire

/* File: hdl/sbr_host.sv */
// Host end: serial master issuing command plus data word transactions
`default_nettype none
module sbr_host
	import sbr_pkg::*;
#(
	parameter int HALF_CYC = SCLK_HALF_CYC
) (
	input  wire logic              clock,
	input  wire logic              reset_n,
	sbr_if.host                    link,
	input  wire logic              start,
	input  wire logic              abort,
	input  wire logic [WORD_W-1:0] cmd_word,
	input  wire logic [7:0]        num_words,
	input  wire logic [WORD_W-1:0] wdata,
	output logic                   wdata_take,
	output logic [WORD_W-1:0]      word_data,
	output logic                   word_valid,
	output logic                   busy
);
	logic                 miso_s;
	logic                 tick;
	logic [7:0]           div_reg;
	logic [7:0]           words_reg;
	logic [BIT_CNT_W-1:0] bit_reg;
	logic [WORD_W-1:0]    tx_reg;
	logic [WORD_W-1:0]    rx_reg;
	sbr_host_state_t      state_reg;

	initial begin
		if (HALF_CYC < MIN_HALF_CYC || HALF_CYC > 255) $error("sbr_host: HALF_CYC out of range");
	end

	// Data from the device enters through two flip-flops
	sbr_sync #(
		.WIDTH(1)
	) u_sync (
		.clock   (clock),
		.reset_n (reset_n),
		.async_in(link.miso_out & link.miso_oe),
		.sync_out(miso_s)
	);

	assign tick = (div_reg == 8'(HALF_CYC - 1));

	// Half period divider for the serial clock
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			div_reg <= '0;
		end else if (state_reg == HST_IDLE || tick) begin
			div_reg <= '0;
		end else begin
			div_reg <= div_reg + 8'h01;
		end
	end

	// Transaction sequencer and shifters
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state_reg  <= HST_IDLE;
			link.sclk  <= 1'h0;
			link.ss_n  <= 1'h1;
			link.mosi  <= 1'h0;
			tx_reg     <= WORD_ZERO;
			rx_reg     <= WORD_ZERO;
			bit_reg    <= '0;
			words_reg  <= '0;
			wdata_take <= 1'h0;
			word_valid <= 1'h0;
			word_data  <= WORD_ZERO;
			busy       <= 1'h0;
		end else begin
			wdata_take <= 1'h0;
			word_valid <= 1'h0;
			if (abort && state_reg != HST_IDLE && state_reg != HST_LAG) begin
				link.sclk <= 1'h0;
				link.ss_n <= 1'h1;
				state_reg <= HST_LAG;
			end else begin
				unique case (state_reg)
					HST_IDLE: begin
						if (start) begin
							link.ss_n <= 1'h0;
							tx_reg    <= cmd_word;
							words_reg <= num_words;
							bit_reg   <= '0;
							busy      <= 1'h1;
							state_reg <= HST_LEAD;
						end
					end
					HST_LEAD: begin
						if (tick) begin
							state_reg <= HST_RUN;
						end
					end
					HST_RUN: begin
						if (tick && !link.sclk) begin
							link.sclk <= 1'h1;
							link.mosi <= tx_reg[WORD_W-1];
							tx_reg    <= {tx_reg[WORD_W-2:0], 1'h0};
						end else if (tick) begin
							link.sclk <= 1'h0;
							rx_reg    <= {rx_reg[WORD_W-2:0], miso_s};
							bit_reg   <= bit_reg + 4'h1;
							if (bit_reg == LAST_BIT) begin
								word_valid <= 1'h1;
								word_data  <= {rx_reg[WORD_W-2:0], miso_s};
								if (words_reg == 8'h00) begin
									state_reg <= HST_LAG;
								end else begin
									words_reg  <= words_reg - 8'h01;
									tx_reg     <= wdata;
									wdata_take <= 1'h1;
								end
							end
						end
					end
					HST_LAG: begin
						if (tick && !link.ss_n) begin
							link.ss_n <= 1'h1;
						end else if (tick) begin
							busy      <= 1'h0;
							state_reg <= HST_IDLE;
						end
					end
				endcase
			end
		end
	end
endmodule
`default_nettype wire

/* File: sim/sbr_asserts.sv */
// Checker on the serial link between host end and device end
`default_nettype none
module sbr_asserts (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic sclk,
	input wire logic ss_n,
	input wire logic mosi,
	input wire logic miso_out,
	input wire logic miso_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	// Link clock and select framing
	property p_sclk_idle; ss_n |-> !sclk; endproperty
	a_sclk_idle: assert property (p_sclk_idle) else $error("sclk high when idle");
	property p_lead; $fell(ss_n) |-> !sclk [*6]; endproperty
	a_lead: assert property (p_lead) else $error("sclk rose too soon");
	property p_high; $rose(sclk) |-> sclk [*6]; endproperty
	a_high: assert property (p_high) else $error("sclk high phase short");
	property p_only_sel; $rose(sclk) |-> !ss_n; endproperty
	a_only_sel: assert property (p_only_sel) else $error("sclk pulse unselected");
	// Data lines steady at the capture edge
	property p_mosi_fall; $fell(sclk) |-> $stable(mosi); endproperty
	a_mosi_fall: assert property (p_mosi_fall) else $error("mosi moved at fall");
	property p_miso_fall; $fell(sclk) && !ss_n |-> $stable(miso_out); endproperty
	a_miso_fall: assert property (p_miso_fall) else $error("miso moved at fall");
	// Output drive follows select
	property p_oe_off; ss_n [*6] |-> !miso_oe && !miso_out; endproperty
	a_oe_off: assert property (p_oe_off) else $error("miso driven idle");
	property p_oe_on; !ss_n [*6] |-> miso_oe; endproperty
	a_oe_on: assert property (p_oe_on) else $error("miso not driven");
	// Main scenarios reached
	c_select: cover property ($fell(ss_n));
	c_drive: cover property ($rose(miso_oe));
	c_one: cover property ($fell(sclk) && miso_out);
endmodule
`default_nettype wire

/* File: sim/spi_burst_register_access_test.sv */
// Bench joining host and device ends over the serial link
`default_nettype none
module spi_burst_register_access_test
	import sbr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic              clock = 1'b0;
	logic              reset_n = 1'b0;
	logic              start = 1'b0;
	logic              abort = 1'b0;
	logic [WORD_W-1:0] cmd_word = 16'h0000;
	logic [7:0]        num_words = 8'h00;
	logic [WORD_W-1:0] wtab [4];
	logic [1:0]        widx;
	logic [WORD_W-1:0] mem [2][32];
	logic [WORD_W-1:0] rx [8];
	logic [WORD_W-1:0] sh;
	logic [4:0]        bitn;
	logic              wdata_take, word_valid, busy, reg_page, reg_wr_stb, reg_rd_stb;
	logic [WORD_W-1:0] word_data, reg_wdata;
	logic [ADDR_W-1:0] reg_addr;
	int                nrx, wr_cnt, rd_cnt, mismatches, checks;
	sbr_if link_if ();
	wire miso_w = link_if.miso_oe ? link_if.miso_out : 1'bZ;
	sbr_host sbr_host_inst (.clock(clock), .reset_n(reset_n), .link(link_if.host),
		.start(start), .abort(abort), .cmd_word(cmd_word), .num_words(num_words),
		.wdata(wtab[widx]), .wdata_take(wdata_take), .word_data(word_data),
		.word_valid(word_valid), .busy(busy));
	sbr_device sbr_device_inst (.clock(clock), .reset_n(reset_n), .link(link_if.device),
		.reg_page(reg_page), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr_stb(reg_wr_stb), .reg_rd_stb(reg_rd_stb), .reg_rdata(mem[reg_page][reg_addr]));
	sbr_asserts sbr_asserts_inst (.clock(clock), .reset_n(reset_n), .sclk(link_if.sclk),
		.ss_n(link_if.ss_n), .mosi(link_if.mosi), .miso_out(link_if.miso_out),
		.miso_oe(link_if.miso_oe));
	always #5 clock = ~clock;
	// Register file model, strobe counts, received words
	always @(posedge clock) begin
		if (reg_wr_stb) begin
			mem[reg_page][reg_addr] <= reg_wdata;
			wr_cnt <= wr_cnt + 1;
		end
		if (reg_rd_stb) rd_cnt <= rd_cnt + 1;
		if (wdata_take) widx <= widx + 2'h1;
		if (word_valid) begin
			rx[nrx[2:0]] <= word_data;
			nrx <= nrx + 1;
		end
	end
	// First word on mosi of each selection, MSB first
	always @(negedge link_if.ss_n) bitn = 5'h00;
	always @(negedge link_if.sclk) if (!link_if.ss_n && bitn < 5'h10) begin
		sh = {sh[14:0], link_if.mosi};
		bitn = bitn + 5'h01;
	end
	task automatic chk(input string what, input logic [WORD_W-1:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One transaction; stop above zero aborts after that many cycles
	task automatic run(input logic [WORD_W-1:0] cmd, input logic [7:0] n, input int stop);
		int t = 0;
		nrx = 0;
		widx = 2'h0;
		cmd_word = cmd;
		num_words = n;
		start = 1'b1;
		@(posedge clock) #1 start = 1'b0;
		if (stop > 0) begin
			repeat (stop) @(posedge clock);
			#1 abort = 1'b1;
			@(posedge clock) #1 abort = 1'b0;
		end
		while (busy !== 1'b0 && t < 8000) begin
			@(posedge clock);
			t++;
		end
		repeat (8) @(posedge clock);
		#1 chk("busy", {15'h0000, busy}, 16'h0000);
		chk("mosi word", sh, cmd);
		chk("idle miso", {15'h0000, miso_w}, {15'h0000, 1'bZ});
	endtask
	// Burst write with a surplus word past the end
	task automatic t_write;
		int w0 = wr_cnt;
		wtab = '{16'hA5C3, 16'h5A3C, 16'h0F0F, 16'hFFFF};
		run(16'h10C5, 8'h04, 0);
		chk("writes", 16'(wr_cnt - w0), 16'h0003);
		for (int i = 0; i < 3; i++) chk("written", mem[1][3 + i], wtab[i]);
		chk("past end", mem[1][6], 16'h0000);
	endtask
	// Burst read with a surplus word past the end
	task automatic t_read;
		int r0 = rd_cnt;
		for (int i = 0; i < 32; i++) mem[0][i] = 16'h1100 + 16'(i);
		run(16'h8087, 8'h07, 0);
		for (int i = 1; i < 7; i++) chk("burst read", rx[i], mem[0][i + 1]);
		chk("read past end", rx[7], WORD_ZERO);
		chk("reads", 16'(rd_cnt - r0), 16'h0006);
	endtask
	// End address not above start: one access only
	task automatic t_single;
		run(16'h8143, 8'h02, 0);
		chk("single read", rx[1], mem[0][5]);
		chk("after single", rx[2], WORD_ZERO);
		wtab[0] = 16'h7E81;
		run(16'h1280, 8'h02, 0);
		chk("single write", mem[1][10], 16'h7E81);
		chk("no spill", mem[1][11], 16'h0000);
	endtask
	// Reserved page codes reach no register
	task automatic t_reserved;
		int w0 = wr_cnt;
		int r0 = rd_cnt;
		run(16'hA000, 8'h01, 0);
		chk("reserved read", rx[1], WORD_ZERO);
		run(16'h3041, 8'h01, 0);
		chk("reserved access", 16'(wr_cnt - w0 + rd_cnt - r0), 16'h0000);
	endtask
	// Deselect mid word, then a fresh command works
	task automatic t_abort;
		int w0 = wr_cnt;
		wtab[0] = 16'hBEEF;
		run(16'h1000, 8'h01, 411);  // Abort lands in the low phase after data bit 9
		chk("partial write", 16'(wr_cnt - w0), 16'h0000);
		chk("untouched", mem[1][0], 16'h0000);
		run(16'h1000, 8'h01, 0);
		run(16'h9000, 8'h01, 0);
		chk("new command", rx[1], 16'hBEEF);
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// Main sequence
	initial begin
		for (int p = 0; p < 2; p++) for (int i = 0; i < 32; i++) mem[p][i] = 16'h0000;
		wtab = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
		widx = 2'h0;
		{nrx, wr_cnt, rd_cnt, mismatches, checks} = '0;
		repeat (3) @(posedge clock);
		#1 reset_n = 1'b1;
		repeat (8) @(posedge clock);
		#1 t_write;
		t_read;
		t_single;
		t_reserved;
		t_abort;
		wrap_up;
	end
	// Watchdog against a hung transfer
	initial begin
		#500000;
		mismatches++;
		wrap_up;
	end
endmodule
`default_nettype wire
